// file: design/pmc_pkg.sv
// Shared constants and types for the power mode and clock control block
package pmc_pkg;
  // Clock source selection codes
  localparam logic [1:0] SRC_HF24 = 2'h0;
  localparam logic [1:0] SRC_HF48 = 2'h1;
  localparam logic [1:0] SRC_LF = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;
  // Divider code after reset: divide by 8
  localparam logic [2:0] DIV_RESET = 3'h3;
  localparam int DIV_W = 7;
  localparam logic [DIV_W-1:0] DIV_ONE = 7'h01;
  // Prescaler of 1.5: two ticks out of every three
  localparam logic [1:0] PRE_LAST = 2'h2;
  // Low-frequency divide by eight for the timers
  localparam logic [2:0] LF_DIV_LAST = 3'h7;
  // Synchronised pin vector layout
  localparam int SYNC_N = 7;
  localparam int PIN_CMP0 = 0;
  localparam int PIN_WAKE_LO = 1;
  localparam int PIN_WAKE_HI = 4;
  localparam int PIN_EXT = 5;
  localparam int PIN_RSTN = 6;
  localparam logic [SYNC_N-1:0] SYNC_RST = 7'h40;
  localparam int TMR_W = 16;
  localparam int PERIPH_N = 8;

  typedef enum logic [2:0] {
    PMC_NORMAL = 3'h0,
    PMC_IDLE = 3'h1,
    PMC_SUSPEND = 3'h2,
    PMC_SNOOZE = 3'h3,
    PMC_STOP = 3'h4,
    PMC_SHUTDOWN = 3'h5
  } pmc_mode_t;

  typedef struct packed {
    logic usb;
    logic spi;
    logic i2c;
    logic port_match;
    logic cmp0;
  } pmc_wake_t;

  typedef struct packed {
    logic [1:0] sel;
    logic [2:0] div;
    logic pre24;
    logic pre48;
  } pmc_clk_cfg_t;

  localparam pmc_clk_cfg_t CLK_CFG_RESET = '{sel: SRC_HF24, div: DIV_RESET, pre24: 1'b0, pre48: 1'b0};
endpackage

// file: design/pmc_timer16.sv
// Auto-reload up counter used for the low-power timers
`timescale 1ns/100ps
module pmc_timer16 #(
  parameter int W = 16
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic run_i,
  input wire logic [W-1:0] reload_i,
  output logic [W-1:0] count_o,
  output logic overflow_o
);
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      count_o <= '0;
      overflow_o <= 1'b0;
    end else if (ce_i) begin
      overflow_o <= 1'b0;
      if (run_i && tick_i) begin
        if (&count_o) begin
          count_o <= reload_i;
          overflow_o <= 1'b1;
        end else begin
          count_o <= count_o + 1'b1;
        end
      end
    end
  end
endmodule

// file: design/pmc_power_clock.sv
// Power mode sequencing, system clock selection and low-power timers
// Function
// - Normal mode keeps core and enabled peripherals clocked.
// - Idle request halts core only; any interrupt returns to normal.
// - Suspend halts clocks, stops both fast oscillators, keeps normal bias.
// - Snooze halts clocks, stops fast oscillators, regulators in low bias.
// - USB, timer 4, SPI, I2C slave, port match, comparator fall wake.
// - Wake from suspend or snooze resumes execution without reset.
// - Timers 3 and 4 may count low-frequency ticks over eight in low power.
// - Timer 4 wakes the device and can chain behind timer 3.
// - Stop keeps core regulator on, holds pins, any reset exits.
// - Shutdown turns the regulator off, holds pins; only pin or power reset.
// - After reset the clock is the 24.5 MHz source divided by eight.
// - Four sources: 24.5 MHz, 48 MHz, 80 kHz, external clock.
// - Divider offers divide by 1, 2, 4, 8, 16, 32, 64, 128.
// - Both fast oscillators offer a 1.5 prescaler before the divider.
// - Clocks of unused digital peripherals are gated off.
`timescale 1ns/100ps
module pmc_power_clock #(
  parameter int PERIPH_N = pmc_pkg::PERIPH_N,
  parameter int TMR_W = pmc_pkg::TMR_W
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic idle_req_i,
  input wire logic suspend_req_i,
  input wire logic snooze_req_i,
  input wire logic stop_req_i,
  input wire logic shutdown_select_bit_i,
  input wire logic interrupt_i,
  input wire logic reset_req_i,
  input wire pmc_pkg::pmc_wake_t wake_pins_i,
  input wire logic reset_pin_n_i,
  input wire logic external_clock_input_i,
  input wire logic hf24_tick_i,
  input wire logic hf48_tick_i,
  input wire logic lf_tick_i,
  input wire logic clk_cfg_wr_i,
  input wire pmc_pkg::pmc_clk_cfg_t clk_cfg_i,
  input wire logic [PERIPH_N-1:0] periph_en_i,
  input wire logic [1:0] tmr_run_i,
  input wire logic [1:0] tmr_lf_i,
  input wire logic tmr_chain_i,
  input wire logic [TMR_W-1:0] t3_reload_i,
  input wire logic [TMR_W-1:0] t4_reload_i,
  output pmc_pkg::pmc_mode_t mode_o,
  output pmc_pkg::pmc_clk_cfg_t clk_cfg_o,
  output logic core_clk_en_o,
  output logic [PERIPH_N-1:0] periph_clk_en_o,
  output logic hf_oscillator_24m_en_o,
  output logic hf_oscillator_48m_en_o,
  output logic reg_low_bias_o,
  output logic ldo_on_o,
  output logic pin_hold_o,
  output logic resume_o,
  output logic sys_reset_o,
  output logic [TMR_W-1:0] t3_count_o,
  output logic [TMR_W-1:0] t4_count_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [pmc_pkg::SYNC_N-1:0] pins_raw, sync1, sync2, sync3, filt, filt_q;

  assign pins_raw = {reset_pin_n_i, external_clock_input_i, wake_pins_i};

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= pmc_pkg::SYNC_RST;
      sync2 <= pmc_pkg::SYNC_RST;
      sync3 <= pmc_pkg::SYNC_RST;
      filt <= pmc_pkg::SYNC_RST;
      filt_q <= pmc_pkg::SYNC_RST;
    end else if (ce_i) begin
      sync1 <= pins_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= ((sync2 ~^ sync3) & sync3) | ((sync2 ^ sync3) & filt);
      filt_q <= filt;
    end
  end

  logic pin_wake, pin_reset, ext_edge;

  assign pin_wake = (|(filt[pmc_pkg::PIN_WAKE_HI:pmc_pkg::PIN_WAKE_LO]
                       & ~filt_q[pmc_pkg::PIN_WAKE_HI:pmc_pkg::PIN_WAKE_LO]))
                    | (~filt[pmc_pkg::PIN_CMP0] & filt_q[pmc_pkg::PIN_CMP0]);
  assign pin_reset = ~filt[pmc_pkg::PIN_RSTN];
  assign ext_edge = filt[pmc_pkg::PIN_EXT] & ~filt_q[pmc_pkg::PIN_EXT];

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencer
  pmc_pkg::pmc_mode_t mode, next_mode;
  logic t4_ovf, any_reset, low_wake;

  assign any_reset = reset_req_i | pin_reset;
  assign low_wake = pin_wake | t4_ovf;

  always_comb begin
    next_mode = mode;
    case (mode)
      pmc_pkg::PMC_NORMAL: begin
        if (stop_req_i) begin
          next_mode = shutdown_select_bit_i ? pmc_pkg::PMC_SHUTDOWN : pmc_pkg::PMC_STOP;
        end else if (suspend_req_i) begin
          next_mode = pmc_pkg::PMC_SUSPEND;
        end else if (snooze_req_i) begin
          next_mode = pmc_pkg::PMC_SNOOZE;
        end else if (idle_req_i) begin
          next_mode = pmc_pkg::PMC_IDLE;
        end
      end
      pmc_pkg::PMC_IDLE: begin
        if (interrupt_i || any_reset) begin
          next_mode = pmc_pkg::PMC_NORMAL;
        end
      end
      pmc_pkg::PMC_SUSPEND, pmc_pkg::PMC_SNOOZE: begin
        if (low_wake || any_reset) begin
          next_mode = pmc_pkg::PMC_NORMAL;
        end
      end
      pmc_pkg::PMC_STOP: begin
        if (any_reset) begin
          next_mode = pmc_pkg::PMC_NORMAL;
        end
      end
      pmc_pkg::PMC_SHUTDOWN: begin
        if (pin_reset) begin
          next_mode = pmc_pkg::PMC_NORMAL;
        end
      end
      default: next_mode = pmc_pkg::PMC_NORMAL;
    endcase
  end

  logic reset_evt;

  assign reset_evt = (mode == pmc_pkg::PMC_SHUTDOWN) ? pin_reset : any_reset;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mode <= pmc_pkg::PMC_NORMAL;
    end else if (ce_i) begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      resume_o <= 1'b0;
      sys_reset_o <= 1'b0;
    end else if (ce_i) begin
      resume_o <= ((mode == pmc_pkg::PMC_SUSPEND) || (mode == pmc_pkg::PMC_SNOOZE)
                   || (mode == pmc_pkg::PMC_IDLE)) && (next_mode == pmc_pkg::PMC_NORMAL) && !any_reset;
      sys_reset_o <= reset_evt;
    end
  end

  logic low_power, clk_run;

  assign low_power = (mode != pmc_pkg::PMC_NORMAL) && (mode != pmc_pkg::PMC_IDLE);
  assign clk_run = !low_power;
  assign mode_o = mode;
  assign hf_oscillator_24m_en_o = clk_run;
  assign hf_oscillator_48m_en_o = clk_run;
  assign reg_low_bias_o = (mode == pmc_pkg::PMC_SNOOZE);
  assign ldo_on_o = (mode != pmc_pkg::PMC_SHUTDOWN);
  assign pin_hold_o = (mode == pmc_pkg::PMC_STOP) || (mode == pmc_pkg::PMC_SHUTDOWN);

  ////////////////////////////////////////////////////////////////////////////
  // System clock selection and division
  pmc_pkg::pmc_clk_cfg_t clk_cfg;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      clk_cfg <= pmc_pkg::CLK_CFG_RESET;
    end else if (ce_i) begin
      if (reset_evt) begin
        clk_cfg <= pmc_pkg::CLK_CFG_RESET;
      end else if (clk_cfg_wr_i) begin
        clk_cfg <= clk_cfg_i;
      end
    end
  end

  assign clk_cfg_o = clk_cfg;

  logic src_tick, pre_on, pre_tick, sys_tick;
  logic [1:0] pre_cnt;
  logic [pmc_pkg::DIV_W-1:0] div_cnt, div_last;

  always_comb begin
    case (clk_cfg.sel)
      pmc_pkg::SRC_HF24: src_tick = hf24_tick_i & hf_oscillator_24m_en_o;
      pmc_pkg::SRC_HF48: src_tick = hf48_tick_i & hf_oscillator_48m_en_o;
      pmc_pkg::SRC_LF: src_tick = lf_tick_i;
      pmc_pkg::SRC_EXT: src_tick = ext_edge;
      default: src_tick = 1'b0;
    endcase
  end

  assign pre_on = ((clk_cfg.sel == pmc_pkg::SRC_HF24) && clk_cfg.pre24)
                  || ((clk_cfg.sel == pmc_pkg::SRC_HF48) && clk_cfg.pre48);
  assign pre_tick = src_tick && clk_run && (!pre_on || (pre_cnt != pmc_pkg::PRE_LAST));
  assign div_last = (pmc_pkg::DIV_ONE << clk_cfg.div) - pmc_pkg::DIV_ONE;
  assign sys_tick = pre_tick && (div_cnt == div_last);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pre_cnt <= '0;
      div_cnt <= '0;
    end else if (ce_i) begin
      if (clk_cfg_wr_i) begin
        pre_cnt <= '0;
        div_cnt <= '0;
      end else begin
        if (src_tick && clk_run && pre_on) begin
          pre_cnt <= (pre_cnt == pmc_pkg::PRE_LAST) ? 2'h0 : pre_cnt + 2'h1;
        end
        if (pre_tick) begin
          div_cnt <= sys_tick ? '0 : div_cnt + 1'b1;
        end
      end
    end
  end

  assign core_clk_en_o = ce_i && sys_tick && (mode == pmc_pkg::PMC_NORMAL);
  assign periph_clk_en_o = {PERIPH_N{ce_i && sys_tick && clk_run}} & periph_en_i;

  ////////////////////////////////////////////////////////////////////////////
  // Low-power timers 3 and 4
  logic [2:0] lf_cnt;
  logic lf8_tick, t3_tick, t4_tick, t3_ovf, sys_periph_tick;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      lf_cnt <= '0;
    end else if (ce_i && lf_tick_i) begin
      lf_cnt <= lf_cnt + 3'h1;
    end
  end

  assign lf8_tick = lf_tick_i && (lf_cnt == pmc_pkg::LF_DIV_LAST);
  assign sys_periph_tick = sys_tick && clk_run;
  assign t3_tick = tmr_lf_i[0] ? lf8_tick : sys_periph_tick;
  assign t4_tick = tmr_chain_i ? t3_ovf : (tmr_lf_i[1] ? lf8_tick : sys_periph_tick);

  pmc_timer16 #(.W(TMR_W)) u_timer3 (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .tick_i(t3_tick),
    .run_i(tmr_run_i[0]),
    .reload_i(t3_reload_i),
    .count_o(t3_count_o),
    .overflow_o(t3_ovf)
  );

  pmc_timer16 #(.W(TMR_W)) u_timer4 (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .tick_i(t4_tick),
    .run_i(tmr_run_i[1]),
    .reload_i(t4_reload_i),
    .count_o(t4_count_o),
    .overflow_o(t4_ovf)
  );
endmodule

// file: dv/pmc_properties.sv
// Checker for the power mode and clock control block
`timescale 1ns/100ps
module pmc_checker #(
  parameter int PERIPH_N = 8
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic stop_req_i,
  input wire logic shutdown_select_bit_i,
  input wire logic interrupt_i,
  input wire logic reset_req_i,
  input wire logic reset_pin_n_i,
  input wire logic [PERIPH_N-1:0] periph_en_i,
  input wire pmc_pkg::pmc_mode_t mode_o,
  input wire logic core_clk_en_o,
  input wire logic [PERIPH_N-1:0] periph_clk_en_o,
  input wire logic hf_oscillator_24m_en_o,
  input wire logic hf_oscillator_48m_en_o,
  input wire logic reg_low_bias_o,
  input wire logic ldo_on_o,
  input wire logic pin_hold_o,
  input wire logic sys_reset_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////
  ldo_off_a: assert property (mode_o == pmc_pkg::PMC_SHUTDOWN |-> !ldo_on_o)
    else $error("regulator on in shutdown");
  ldo_kept_a: assert property (mode_o == pmc_pkg::PMC_STOP |-> ldo_on_o && pin_hold_o)
    else $error("stop lost regulator or pin hold");
  pins_held_a: assert property (mode_o == pmc_pkg::PMC_SHUTDOWN |-> pin_hold_o)
    else $error("pins not held in shutdown");
  low_bias_a: assert property (reg_low_bias_o == (mode_o == pmc_pkg::PMC_SNOOZE))
    else $error("bias mode wrong");
  osc_stopped_a: assert property (mode_o inside {[pmc_pkg::PMC_SUSPEND:pmc_pkg::PMC_SHUTDOWN]}
    |-> !hf_oscillator_24m_en_o && !hf_oscillator_48m_en_o) else $error("fast oscillator running");
  core_gate_a: assert property (core_clk_en_o |-> mode_o == pmc_pkg::PMC_NORMAL)
    else $error("core clocked outside normal");
  periph_gate_a: assert property (|periph_clk_en_o |-> (periph_clk_en_o & ~periph_en_i) == '0)
    else $error("unused peripheral clocked");
  stop_pick_a: assert property (ce_i && mode_o == pmc_pkg::PMC_NORMAL && stop_req_i && !reset_req_i
    |=> mode_o == ($past(shutdown_select_bit_i) ? pmc_pkg::PMC_SHUTDOWN : pmc_pkg::PMC_STOP))
    else $error("stop request chose wrong mode");
  idle_wake_a: assert property (ce_i && mode_o == pmc_pkg::PMC_IDLE && interrupt_i && !reset_req_i
    |-> ##1 mode_o == pmc_pkg::PMC_NORMAL) else $error("interrupt did not end idle");
  pin_only_a: assert property (reset_pin_n_i [*6] ##0 mode_o == pmc_pkg::PMC_SHUTDOWN |-> !sys_reset_o)
    else $error("shutdown left without pin reset");
  ////////////////////////////////////////////////////////////////
  idle_c: cover property (mode_o == pmc_pkg::PMC_IDLE);
  snooze_c: cover property (mode_o == pmc_pkg::PMC_SNOOZE);
  shutdown_c: cover property (mode_o == pmc_pkg::PMC_SHUTDOWN ##1 mode_o == pmc_pkg::PMC_NORMAL);
endmodule
bind pmc_power_clock pmc_checker #(.PERIPH_N(PERIPH_N)) u_chk (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
  .stop_req_i(stop_req_i), .shutdown_select_bit_i(shutdown_select_bit_i), .interrupt_i(interrupt_i),
  .reset_req_i(reset_req_i), .reset_pin_n_i(reset_pin_n_i), .periph_en_i(periph_en_i), .mode_o(mode_o),
  .core_clk_en_o(core_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
  .hf_oscillator_24m_en_o(hf_oscillator_24m_en_o), .hf_oscillator_48m_en_o(hf_oscillator_48m_en_o),
  .reg_low_bias_o(reg_low_bias_o), .ldo_on_o(ldo_on_o), .pin_hold_o(pin_hold_o), .sys_reset_o(sys_reset_o));

// file: dv/tb_top.sv
// Testbench for the power mode and clock control block
`timescale 1ns/100ps
module tb_top;
  logic clock_i = 0, rst_i = 1, idle_r = 0, susp_r = 0, snz_r = 0, stop_r = 0, sds = 0, irq = 0, rreq = 0;
  logic pin_n = 1, t24 = 1, t48 = 1, tlf = 1, cwr = 0, core_en, ldo, hold, bias, o24, o48, res, srst;
  pmc_pkg::pmc_wake_t wake = 5'h01;
  pmc_pkg::pmc_clk_cfg_t cfg = pmc_pkg::CLK_CFG_RESET, cfg_o;
  pmc_pkg::pmc_mode_t mode;
  logic [7:0] pen = 8'h01, pclk;
  logic [1:0] trun = 0, tlfs = 0;
  logic chain = 0, ext = 0;
  logic [15:0] t3, t4, rl3 = 16'hFFFC, rl4 = 16'hFF00;
  int n_fail = 0, samples_checked = 0, cycles = 0, n_res = 0, n_rst = 0;
  pmc_power_clock DUT (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1), .idle_req_i(idle_r), .suspend_req_i(susp_r),
    .snooze_req_i(snz_r), .stop_req_i(stop_r), .shutdown_select_bit_i(sds), .interrupt_i(irq), .reset_req_i(rreq),
    .wake_pins_i(wake), .reset_pin_n_i(pin_n), .external_clock_input_i(ext), .hf24_tick_i(t24),
    .hf48_tick_i(t48), .lf_tick_i(tlf), .clk_cfg_wr_i(cwr), .clk_cfg_i(cfg), .periph_en_i(pen),
    .tmr_run_i(trun), .tmr_lf_i(tlfs), .tmr_chain_i(chain), .t3_reload_i(rl3), .t4_reload_i(rl4),
    .mode_o(mode), .clk_cfg_o(cfg_o), .core_clk_en_o(core_en), .periph_clk_en_o(pclk),
    .hf_oscillator_24m_en_o(o24), .hf_oscillator_48m_en_o(o48), .reg_low_bias_o(bias), .ldo_on_o(ldo),
    .pin_hold_o(hold), .resume_o(res), .sys_reset_o(srst), .t3_count_o(t3), .t4_count_o(t4));
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  ////////////////////////////////////////////////////////////////
  always @(negedge clock_i) begin
    n_res <= n_res + (res === 1'b1);
    n_rst <= n_rst + (srst === 1'b1);
  end
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles[0]) ext <= ~ext;
    if (cycles == 80000) begin
      n_fail++;
      give_verdict();
    end
  end
  task check(string name, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task set_cfg(logic [1:0] s, logic [2:0] d, logic p24, logic p48);
    @(posedge clock_i);
    cfg <= '{sel: s, div: d, pre24: p24, pre48: p48};
    cwr <= 1;
    @(posedge clock_i);
    cwr <= 0;
  endtask
  task wait_mode(pmc_pkg::pmc_mode_t m, int lim);
    for (int i = 0; i < lim && mode !== m; i++) @(negedge clock_i);
    check("mode", 16'(mode), 16'(m));
  endtask
  task count_core(int n, int exp);
    int c;
    c = 0;
    repeat (n) begin
      @(negedge clock_i);
      c += (core_en === 1'b1);
    end
    check("core ticks", 16'(c), 16'(exp));
  endtask
  task count_periph(int n, int b, int exp);
    int c;
    c = 0;
    repeat (n) begin
      @(negedge clock_i);
      c += (pclk[b] === 1'b1);
    end
    check("periph ticks", 16'(c), 16'(exp));
  endtask
  ////////////////////////////////////////////////////////////////
  task t_clocks();
    check("cfg reset", 16'(cfg_o), 16'(pmc_pkg::CLK_CFG_RESET));
    count_core(128, 16);
    for (int d = 0; d < 8; d++) begin
      set_cfg(pmc_pkg::SRC_HF24, d[2:0], 0, 0);
      count_core(128, 128 >> d);
    end
    for (int s = 0; s < 3; s++) begin
      set_cfg(s[1:0], 3'h0, 0, 0);
      count_core(64, 64);
    end
    set_cfg(pmc_pkg::SRC_EXT, 3'h0, 0, 0);
    count_core(64, 16);
    set_cfg(pmc_pkg::SRC_HF24, 3'h0, 1, 0);
    count_core(126, 84);
    set_cfg(pmc_pkg::SRC_HF48, 3'h0, 0, 1);
    count_core(126, 84);
    $display("clock tests done");
  endtask
  task t_idle();
    @(posedge clock_i) idle_r <= 1;
    @(posedge clock_i) idle_r <= 0;
    wait_mode(pmc_pkg::PMC_IDLE, 2);
    count_core(8, 0);
    count_periph(6, 0, 4);
    count_periph(6, 1, 0);
    check("idle osc", 16'(o24), 16'h0001);
    @(posedge clock_i) irq <= 1;
    @(posedge clock_i) irq <= 0;
    wait_mode(pmc_pkg::PMC_NORMAL, 2);
    count_core(6, 4);
    check("idle resume", 16'(n_res), 16'h0001);
    $display("idle test done");
  endtask
  task t_lowpower(bit snooze);
    int r0, s0;
    logic [15:0] c0;
    r0 = n_res;
    s0 = n_rst;
    set_cfg(pmc_pkg::SRC_HF24, 3'h0, 0, 0);
    @(posedge clock_i) begin
      susp_r <= !snooze;
      snz_r <= snooze;
    end
    @(posedge clock_i) begin
      susp_r <= 0;
      snz_r <= 0;
    end
    wait_mode(snooze ? pmc_pkg::PMC_SNOOZE : pmc_pkg::PMC_SUSPEND, 2);
    check("bias", 16'(bias), 16'(snooze));
    check("osc", 16'({o24, o48}), 16'h0000);
    count_core(8, 0);
    count_periph(8, 0, 0);
    c0 = t3;
    repeat (16) @(negedge clock_i);
    check("t3 low power", t3, c0 + 16'h0002);
    @(posedge clock_i) wake <= snooze ? 5'h00 : 5'h11;
    wait_mode(pmc_pkg::PMC_NORMAL, 8);
    @(negedge clock_i);
    check("resume", 16'(n_res - r0), 16'h0001);
    check("no reset", 16'(n_rst - s0), 16'h0000);
    @(posedge clock_i) wake <= 5'h01;
    repeat (6) @(posedge clock_i);
    $display("low power test done");
  endtask
  task t_stop(bit shut);
    int s0;
    s0 = n_rst;
    set_cfg(pmc_pkg::SRC_HF48, 3'h5, 0, 0);
    @(posedge clock_i) sds <= shut;
    @(posedge clock_i) stop_r <= 1;
    @(posedge clock_i) begin
      stop_r <= 0;
      sds <= !shut;
    end
    wait_mode(shut ? pmc_pkg::PMC_SHUTDOWN : pmc_pkg::PMC_STOP, 2);
    check("ldo", 16'(ldo), 16'(!shut));
    check("hold", 16'(hold), 16'h0001);
    @(posedge clock_i) rreq <= 1;
    @(posedge clock_i) rreq <= 0;
    if (shut) begin
      repeat (6) @(negedge clock_i);
      check("shutdown kept", 16'(mode), 16'(pmc_pkg::PMC_SHUTDOWN));
      @(posedge clock_i) pin_n <= 0;
      repeat (3) @(posedge clock_i);
      pin_n <= 1;
    end
    wait_mode(pmc_pkg::PMC_NORMAL, 10);
    repeat (8) @(negedge clock_i);
    check("reset seen", 16'(n_rst - s0 > 0), 16'h0001);
    check("cfg restored", 16'(cfg_o), 16'(pmc_pkg::CLK_CFG_RESET));
    $display("stop test done");
  endtask
  task t_timers();
    int r0;
    logic [15:0] c0;
    r0 = n_res;
    set_cfg(pmc_pkg::SRC_HF24, 3'h0, 0, 0);
    @(posedge clock_i) begin
      trun <= 2'h3;
      tlfs <= 2'h0;
    end
    @(negedge clock_i);
    c0 = t4;
    repeat (16) @(negedge clock_i);
    check("t4 system ticks", t4, c0 + 16'h0010);
    while (t4 < 16'hFFF0) @(negedge clock_i);
    @(posedge clock_i) begin
      tlfs <= 2'h2;
      susp_r <= 1;
    end
    @(posedge clock_i) susp_r <= 0;
    wait_mode(pmc_pkg::PMC_SUSPEND, 2);
    wait_mode(pmc_pkg::PMC_NORMAL, 140);
    check("t4 reload", t4, rl4);
    @(negedge clock_i);
    check("t4 resume", 16'(n_res - r0), 16'h0001);
    @(posedge clock_i) chain <= 1;
    @(negedge clock_i);
    c0 = t4;
    repeat (16) @(negedge clock_i);
    check("t4 chained", t4, c0 + 16'h0004);
    $display("timer test done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clock_i);
    rst_i <= 0;
    trun <= 2'h1;
    tlfs <= 2'h1;
    @(negedge clock_i);
    t_clocks();
    t_idle();
    t_lowpower(0);
    t_lowpower(1);
    t_stop(0);
    t_stop(1);
    t_timers();
    give_verdict();
  end
endmodule
